// >>> rtl/pcm_pkg.sv
// Function
// - map the sensor's 1,800-revolution span onto the user coordinate range at start
// - sample generation selection, range, ratio and offset only at power-on
// - regenerate the initial coordinate on every power-on, wrap enabled or not
// - with wrap enabled, preset present position when leaving the wrap range
// - crossing the wrap boundary jumps to the opposite-signed range end
// - offset ratio puts that share of the range on the negative side
// - separate 32-bit step counter, never preset by wrapping
// - step counter is signed and rolls over at both extremes
// - coordinate-established flag high exactly while a coordinate is set
// - without coordinate refuse high-speed home, and absolute moves unless permitted
// - absolute-without-coordinate permission: 0 disable, 1 enable, default 0
// - factory home present in sensor raises factory-home flag, never changes
// - home or preset raises user-home flag; preset clear removes user home
// - newly set user home is written to non-volatile memory
// - preset loads command and feedback position with preset value, sets home
// - after a mechanical home is set, coordinates centre on it
// - generation selection 0 takes sensor values, 1 takes manual values
// - flag low at factory state, after clear, resolution change after a nonzero preset, during homing
package pcm_pkg;
   localparam int REV_W = 11;
   localparam int STEP_W = 16;
   localparam int RATIO_W = 14;
   localparam int POS_W = 32;
   localparam int PROD_W = 46;
   localparam int ACC_W = 34;
   localparam logic [REV_W-1:0] SPAN_REVS = 11'h708;
   localparam logic [RATIO_W-1:0] RATIO_FULL = 14'h2710;
   localparam logic [5:0] DIV_LAST = 6'h2D;
   localparam logic SEL_SENSOR = 1'b0;
   localparam logic SEL_MANUAL = 1'b1;
   localparam logic [POS_W-1:0] POS_RST = 32'h0;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_DIV = 2'b01,
      ST_MOD = 2'b10,
      ST_RUN = 2'b11
   } init_state_t;
endpackage : pcm_pkg

// >>> rtl/position_coordinate_manager.sv
`timescale 1ns/1ns
module position_coordinate_manager (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sensor_valid_i,
   input wire logic [10:0] sensor_rev_i,
   input wire logic [15:0] sensor_step_i,
   input wire logic [15:0] steps_per_rev_i,
   input wire logic sensor_factory_home_i,
   input wire logic sensor_user_home_i,
   input wire logic [31:0] sensor_home_abs_i,
   input wire logic [10:0] sensor_range_rev_i,
   input wire logic [13:0] sensor_ratio_i,
   input wire logic [31:0] sensor_offset_i,
   input wire logic sensor_wrap_en_i,
   input wire logic coord_sel_i,
   input wire logic [10:0] man_range_rev_i,
   input wire logic [13:0] man_ratio_i,
   input wire logic [31:0] man_offset_i,
   input wire logic man_wrap_en_i,
   input wire logic cmd_step_i,
   input wire logic cmd_dir_i,
   input wire logic fb_step_i,
   input wire logic fb_dir_i,
   input wire logic preset_i,
   input wire logic [31:0] preset_pos_i,
   input wire logic preset_clear_i,
   input wire logic home_busy_i,
   input wire logic home_done_i,
   input wire logic resolution_change_i,
   input wire logic abs_req_i,
   input wire logic hs_home_req_i,
   input wire logic abs_permit_i,
   output logic init_done_o,
   output logic [31:0] cmd_pos_o,
   output logic [31:0] fb_pos_o,
   output logic [31:0] step_count_o,
   output logic coordinate_established_flag_o,
   output logic factory_home_flag_o,
   output logic user_home_flag_o,
   output logic nvm_write_o,
   output logic [31:0] nvm_data_o,
   output logic abs_accept_o,
   output logic abs_refuse_o,
   output logic hs_home_accept_o,
   output logic hs_home_refuse_o
);

   // plus or minus one, rolling over at the 32-bit ends
   function automatic logic [31:0] step_one(
      input logic [31:0] p,
      input logic up
   );
      step_one = up ? p + 32'h1 : p - 32'h1;
   endfunction : step_one

   // one step of a coordinate, folding at the wrap range ends
   function automatic logic [31:0] wrap_step(
      input logic [31:0] p,
      input logic up,
      input logic en,
      input logic [31:0] lo,
      input logic [31:0] hi
   );
      logic [31:0] top;
      top = hi - 32'h1;
      if (!en) begin
         wrap_step = step_one(p, up);
      end else if (up) begin
         wrap_step = (p == top) ? lo : p + 32'h1;
      end else begin
         wrap_step = (p == lo) ? top : p - 32'h1;
      end
   endfunction : wrap_step

   pcm_pkg::init_state_t state_q;
   logic [10:0] range_q;
   logic [15:0] spr_q;
   logic [31:0] offset_q;
   logic wrap_en_q;
   logic [31:0] abs_q;
   logic [31:0] home_abs_q;
   logic fhome_q;
   logic uhome_q;
   logic lost_q;
   logic preset_nz_q;
   logic established_q;
   logic [5:0] cnt_q;
   logic [45:0] quo_q;
   logic [13:0] rem_q;
   logic [33:0] acc_q;
   logic [31:0] neg_q;
   logic [31:0] cmd_pos_q;
   logic [31:0] fb_pos_q;
   logic [31:0] step_count_q;
   logic nvm_write_q;
   logic [31:0] nvm_data_q;
   logic abs_accept_q;
   logic abs_refuse_q;
   logic hs_accept_q;
   logic hs_refuse_q;

   logic [10:0] range_d;
   logic [13:0] ratio_d;
   logic [31:0] offset_d;
   logic wrap_en_d;
   logic [31:0] range_steps;
   logic [31:0] range_steps_d;
   logic [33:0] span_steps;
   logic [14:0] rem_s;
   logic rem_ge;
   logic [45:0] quo_next;
   logic [31:0] neg_d;
   logic [31:0] lo;
   logic [31:0] hi;
   logic run;
   logic home_set;
   logic div_end;
   logic mod_end;
   logic abs_ok;
   logic [31:0] gen_pos;

   // parameter source selection, only consumed while waiting at power-on
   always_comb begin
      if (coord_sel_i == pcm_pkg::SEL_MANUAL) begin
         range_d = man_range_rev_i;
         ratio_d = man_ratio_i;
         offset_d = man_offset_i;
         wrap_en_d = man_wrap_en_i;
      end else begin
         range_d = sensor_range_rev_i;
         ratio_d = sensor_ratio_i;
         offset_d = sensor_offset_i;
         wrap_en_d = sensor_wrap_en_i;
      end
      // zero range is not usable, fall back to the whole span
      if (range_d == 11'h0) begin
         range_d = pcm_pkg::SPAN_REVS;
      end
   end

   assign range_steps = 32'(range_q * spr_q);
   assign range_steps_d = 32'(range_d * steps_per_rev_i);
   assign span_steps = 34'(pcm_pkg::SPAN_REVS * spr_q);
   // restoring divide by full scale, one quotient bit a cycle
   assign rem_s = {rem_q, quo_q[45]};
   assign rem_ge = rem_s >= {1'b0, pcm_pkg::RATIO_FULL};
   assign quo_next = {quo_q[44:0], rem_ge};
   assign neg_d = quo_next[31:0] + offset_q;
   assign lo = 32'h0 - neg_q;
   assign hi = range_steps - neg_q;
   assign run = state_q == pcm_pkg::ST_RUN;
   assign home_set = run && (preset_i || home_done_i);
   assign div_end = state_q == pcm_pkg::ST_DIV && cnt_q == pcm_pkg::DIV_LAST;
   assign mod_end = state_q == pcm_pkg::ST_MOD && acc_q < 34'(range_steps);
   assign abs_ok = run && (established_q || abs_permit_i);
   assign gen_pos = acc_q[31:0] - neg_q;

   // initial coordinate generation sequence
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= pcm_pkg::ST_WAIT;
         cnt_q <= 6'h0;
         quo_q <= 46'h0;
         rem_q <= 14'h0;
         acc_q <= 34'h0;
      end else begin
         case (state_q)
            pcm_pkg::ST_WAIT: begin
               if (sensor_valid_i) begin
                  quo_q <= 46'(range_steps_d * ratio_d);
                  rem_q <= 14'h0;
                  cnt_q <= 6'h0;
                  state_q <= pcm_pkg::ST_DIV;
               end
            end
            pcm_pkg::ST_DIV: begin
               quo_q <= quo_next;
               rem_q <= rem_ge ? 14'(rem_s - {1'b0, pcm_pkg::RATIO_FULL}) : rem_s[13:0];
               cnt_q <= cnt_q + 6'h1;
               if (cnt_q == pcm_pkg::DIV_LAST) begin
                  // distance from stored home, biased by negative share
                  acc_q <= 34'(abs_q) + span_steps - 34'(home_abs_q) + 34'(neg_d);
                  state_q <= pcm_pkg::ST_MOD;
               end
            end
            pcm_pkg::ST_MOD: begin
               if (acc_q >= 34'(range_steps)) begin
                  acc_q <= acc_q - 34'(range_steps);
               end else begin
                  state_q <= pcm_pkg::ST_RUN;
               end
            end
            pcm_pkg::ST_RUN: begin
               state_q <= pcm_pkg::ST_RUN;
            end
            default: begin
               state_q <= pcm_pkg::ST_WAIT;
            end
         endcase
      end
   end

   // power-on sample of generation parameters and sensor image
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         range_q <= pcm_pkg::SPAN_REVS;
         spr_q <= 16'h0;
         offset_q <= 32'h0;
         wrap_en_q <= 1'b0;
         abs_q <= 32'h0;
         home_abs_q <= 32'h0;
      end else if (state_q == pcm_pkg::ST_WAIT && sensor_valid_i) begin
         range_q <= range_d;
         spr_q <= steps_per_rev_i;
         offset_q <= offset_d;
         wrap_en_q <= wrap_en_d;
         abs_q <= 32'(sensor_rev_i * steps_per_rev_i) + 32'(sensor_step_i);
         home_abs_q <= (sensor_factory_home_i || sensor_user_home_i) ? sensor_home_abs_i
                                                                      : 32'h0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         neg_q <= 32'h0;
      end else if (div_end) begin
         neg_q <= neg_d;
      end
   end

   // command and feedback coordinates
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cmd_pos_q <= pcm_pkg::POS_RST;
         fb_pos_q <= pcm_pkg::POS_RST;
      end else if (mod_end) begin
         cmd_pos_q <= gen_pos;
         fb_pos_q <= gen_pos;
      end else if (home_set) begin
         cmd_pos_q <= preset_pos_i;
         fb_pos_q <= preset_pos_i;
      end else if (run) begin
         if (cmd_step_i) begin
            cmd_pos_q <= wrap_step(cmd_pos_q, cmd_dir_i, wrap_en_q, lo, hi);
         end
         if (fb_step_i) begin
            fb_pos_q <= wrap_step(fb_pos_q, fb_dir_i, wrap_en_q, lo, hi);
         end
      end
   end

   // free-running motor step counter, untouched by wrap and preset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         step_count_q <= pcm_pkg::POS_RST;
      end else if (cmd_step_i) begin
         step_count_q <= step_one(step_count_q, cmd_dir_i);
      end
   end

   // home flags
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fhome_q <= 1'b0;
         uhome_q <= 1'b0;
      end else if (state_q == pcm_pkg::ST_WAIT) begin
         if (sensor_valid_i) begin
            fhome_q <= sensor_factory_home_i;
            uhome_q <= sensor_user_home_i;
         end
      end else if (home_set) begin
         uhome_q <= 1'b1;
      end else if (preset_clear_i) begin
         uhome_q <= 1'b0;
      end
   end

   // coordinate loss bookkeeping; a home set wins over a clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         lost_q <= 1'b0;
         preset_nz_q <= 1'b0;
      end else if (home_set) begin
         lost_q <= 1'b0;
         preset_nz_q <= preset_pos_i != 32'h0;
      end else if (preset_clear_i) begin
         lost_q <= 1'b1;
      end else if (resolution_change_i && preset_nz_q) begin
         lost_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         established_q <= 1'b0;
      end else begin
         established_q <= run && (fhome_q || uhome_q) && !lost_q && !home_busy_i;
      end
   end

   // user home goes to non-volatile memory, so only on an actual set
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         nvm_write_q <= 1'b0;
         nvm_data_q <= 32'h0;
      end else begin
         nvm_write_q <= home_set;
         if (home_set) begin
            nvm_data_q <= preset_pos_i;
         end
      end
   end

   // operation gating
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         abs_accept_q <= 1'b0;
         abs_refuse_q <= 1'b0;
         hs_accept_q <= 1'b0;
         hs_refuse_q <= 1'b0;
      end else begin
         abs_accept_q <= abs_req_i && abs_ok;
         abs_refuse_q <= abs_req_i && !abs_ok;
         hs_accept_q <= hs_home_req_i && established_q;
         hs_refuse_q <= hs_home_req_i && !established_q;
      end
   end

   assign init_done_o = run;
   assign cmd_pos_o = cmd_pos_q;
   assign fb_pos_o = fb_pos_q;
   assign step_count_o = step_count_q;
   assign coordinate_established_flag_o = established_q;
   assign factory_home_flag_o = fhome_q;
   assign user_home_flag_o = uhome_q;
   assign nvm_write_o = nvm_write_q;
   assign nvm_data_o = nvm_data_q;
   assign abs_accept_o = abs_accept_q;
   assign abs_refuse_o = abs_refuse_q;
   assign hs_home_accept_o = hs_accept_q;
   assign hs_home_refuse_o = hs_refuse_q;

endmodule : position_coordinate_manager

// >>> tb/pcm_sensor.sv
`timescale 1ns/1ns
module pcm_sensor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic mode_i,
   output logic sensor_valid_i,
   output logic [10:0] sensor_rev_i,
   output logic [15:0] sensor_step_i,
   output logic sensor_factory_home_i,
   output logic sensor_user_home_i,
   output logic [31:0] sensor_home_abs_i,
   output logic [10:0] sensor_range_rev_i,
   output logic [13:0] sensor_ratio_i,
   output logic [31:0] sensor_offset_i,
   output logic sensor_wrap_en_i
);
   logic [1:0] dly_q;
   // image settles a few cycles after power-on
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) dly_q <= 2'h0;
      else if (dly_q != 2'h3) dly_q <= dly_q + 2'h1;
   end
   assign sensor_valid_i = (dly_q == 2'h3);
   assign sensor_rev_i = 11'h001;
   assign sensor_step_i = 16'h0001;
   assign sensor_factory_home_i = mode_i;
   assign sensor_user_home_i = 1'b0;
   assign sensor_home_abs_i = 32'h0;
   assign sensor_range_rev_i = 11'h012;
   assign sensor_ratio_i = 14'h2648;
   assign sensor_offset_i = 32'h0;
   assign sensor_wrap_en_i = 1'b0;
endmodule : pcm_sensor

// >>> tb/pcm_checker.sv
`timescale 1ns/1ns
module pcm_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cmd_step_i,
   input wire logic cmd_dir_i,
   input wire logic preset_i,
   input wire logic [31:0] preset_pos_i,
   input wire logic preset_clear_i,
   input wire logic home_busy_i,
   input wire logic home_done_i,
   input wire logic abs_req_i,
   input wire logic hs_home_req_i,
   input wire logic abs_permit_i,
   input wire logic init_done_o,
   input wire logic [31:0] cmd_pos_o,
   input wire logic [31:0] fb_pos_o,
   input wire logic [31:0] step_count_o,
   input wire logic coordinate_established_flag_o,
   input wire logic factory_home_flag_o,
   input wire logic user_home_flag_o,
   input wire logic nvm_write_o,
   input wire logic [31:0] nvm_data_o,
   input wire logic abs_accept_o,
   input wire logic abs_refuse_o,
   input wire logic hs_home_accept_o,
   input wire logic hs_home_refuse_o
);
   wire est = coordinate_established_flag_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   abs_take_a: assert property (
      abs_req_i && init_done_o && (est || abs_permit_i) |=> abs_accept_o && !abs_refuse_o)
      else $error("absolute move not accepted");
   abs_deny_a: assert property (
      abs_req_i && !est && !abs_permit_i |=> abs_refuse_o && !abs_accept_o)
      else $error("absolute move not refused");
   hs_deny_a: assert property (hs_home_req_i && !est |=> hs_home_refuse_o)
      else $error("fast homing not refused");
   hs_take_a: assert property (hs_home_req_i && est |=> hs_home_accept_o)
      else $error("fast homing not accepted");
   preset_load_a: assert property (
      init_done_o && preset_i |=> cmd_pos_o == $past(preset_pos_i)
      && fb_pos_o == $past(preset_pos_i) && user_home_flag_o)
      else $error("preset not loaded");
   home_store_a: assert property (
      init_done_o && preset_i |=> nvm_write_o && nvm_data_o == $past(preset_pos_i))
      else $error("home not stored");
   count_step_a: assert property (
      cmd_step_i |=> step_count_o == $past(step_count_o)
      + ($past(cmd_dir_i) ? 32'h1 : 32'hFFFFFFFF))
      else $error("step counter wrong");
   count_hold_a: assert property (!cmd_step_i |=> $stable(step_count_o))
      else $error("step counter moved");
   busy_drop_a: assert property (home_busy_i |=> !est)
      else $error("coordinate flag high while homing");
   clear_drop_a: assert property (
      preset_clear_i && !preset_i && !home_done_i |=> !user_home_flag_o ##1 !est)
      else $error("clear did not drop home");
   factory_fixed_a: assert property ($past(init_done_o) |-> $stable(factory_home_flag_o))
      else $error("factory flag changed");
   early_low_a: assert property (!init_done_o |-> !est)
      else $error("coordinate flag before generation");
   cover property (init_done_o && preset_i);
   cover property (abs_req_i && !est && abs_permit_i);
   cover property (hs_home_req_i && est);
endmodule : pcm_checker

// >>> tb/position_coordinate_manager_bench.sv
`timescale 1ns/1ns
module position_coordinate_manager_bench;
   localparam logic [7:0] CS = 8'h80, FS = 8'h40, PR = 8'h20, CL = 8'h10;
   localparam logic [7:0] HD = 8'h08, RC = 8'h04, AB = 8'h02, HS = 8'h01;
   logic clk_i = 1'b0, reset_i = 1'b1, mode = 1'b0;
   logic sensor_valid_i, sensor_factory_home_i, sensor_user_home_i, sensor_wrap_en_i;
   logic [10:0] sensor_rev_i, sensor_range_rev_i;
   logic [15:0] sensor_step_i;
   logic [13:0] sensor_ratio_i;
   logic [31:0] sensor_home_abs_i, sensor_offset_i;
   logic [15:0] steps_per_rev_i = 16'h0004;
   logic coord_sel_i = 1'b1, man_wrap_en_i = 1'b1, cmd_dir_i = 1'b1, fb_dir_i = 1'b1;
   logic [10:0] man_range_rev_i = 11'h012;
   logic [13:0] man_ratio_i = 14'h1388;
   logic [31:0] man_offset_i = 32'h2, preset_pos_i = 32'h64;
   logic home_busy_i = 1'b0, abs_permit_i = 1'b0;
   logic [7:0] pl = 8'h00;
   logic [4:0] cap = 5'h00;
   logic cmd_step_i, fb_step_i, preset_i, preset_clear_i, home_done_i;
   logic resolution_change_i, abs_req_i, hs_home_req_i;
   logic init_done_o, coordinate_established_flag_o, factory_home_flag_o, user_home_flag_o;
   logic nvm_write_o, abs_accept_o, abs_refuse_o, hs_home_accept_o, hs_home_refuse_o;
   logic [31:0] cmd_pos_o, fb_pos_o, step_count_o, nvm_data_o;
   int bad_count = 0;
   int compares = 0;
   assign {cmd_step_i, fb_step_i, preset_i, preset_clear_i} = pl[7:4];
   assign {home_done_i, resolution_change_i, abs_req_i, hs_home_req_i} = pl[3:0];
   wire [3:0] rsp = {abs_accept_o, abs_refuse_o, hs_home_accept_o, hs_home_refuse_o};
   wire [2:0] fl = {coordinate_established_flag_o, factory_home_flag_o, user_home_flag_o};
   always #5 clk_i = ~clk_i;
   position_coordinate_manager DUT (.*);
   pcm_sensor SNS (.*, .mode_i(mode));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // one-cycle strobe, then one settle cycle
   task automatic pulse(input logic [7:0] v);
      @(negedge clk_i);
      pl = v;
      @(negedge clk_i);
      cap = {nvm_write_o, rsp};
      pl = 8'h00;
      @(negedge clk_i);
   endtask : pulse

   task automatic pwr(input logic m);
      int n;
      mode = m;
      reset_i = 1'b1;
      repeat (20) @(negedge clk_i);
      reset_i = 1'b0;
      for (n = 0; n < 3000 && init_done_o !== 1'b1; n++) @(negedge clk_i);
      if (n < 3000) @(negedge clk_i);
      else begin
         bad_count++;
         results();
      end
   endtask : pwr

   initial begin
      pwr(1'b0);
      chk(cmd_pos_o, 32'h5);
      chk(fb_pos_o, 32'h5);
      chk(32'(fl), 32'h0);
      man_offset_i = 32'h0;
      pulse(AB | HS);
      chk(32'(cap), 32'h5);
      abs_permit_i = 1'b1;
      pulse(AB);
      chk(32'(cap), 32'h8);
      abs_permit_i = 1'b0;
      repeat (28) pulse(CS | FS);
      chk(cmd_pos_o, 32'h21);
      pulse(CS | FS);
      chk(cmd_pos_o, 32'hFFFFFFDA);
      chk(fb_pos_o, 32'hFFFFFFDA);
      cmd_dir_i = 1'b0;
      fb_dir_i = 1'b0;
      pulse(CS | FS);
      chk(cmd_pos_o, 32'h21);
      chk(step_count_o, 32'h1C);
      pulse(PR);
      chk(cmd_pos_o, 32'h64);
      chk(fb_pos_o, 32'h64);
      chk(32'(cap), 32'h10);
      chk(nvm_data_o, 32'h64);
      chk(32'(fl), 32'h5);
      pulse(HS | AB);
      chk(32'(cap), 32'hA);
      pulse(FS);
      chk(fb_pos_o, 32'h63);
      pulse(RC);
      chk(32'(fl), 32'h1);
      preset_pos_i = 32'h0;
      pulse(PR);
      pulse(RC);
      chk(32'(fl), 32'h5);
      home_busy_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk(32'(fl), 32'h1);
      home_busy_i = 1'b0;
      pulse(HD);
      chk(32'(fl), 32'h5);
      chk(cmd_pos_o, 32'h0);
      pulse(CL);
      chk(32'(fl), 32'h0);
      coord_sel_i = 1'b0;
      pwr(1'b1);
      chk(cmd_pos_o, 32'hFFFFFFBD);
      chk(32'(fl), 32'h6);
      pulse(CS);
      chk(cmd_pos_o, 32'hFFFFFFBC);
      chk(step_count_o, 32'hFFFFFFFF);
      pulse(CL);
      chk(32'(fl[1]), 32'h1);
      results();
   end
endmodule : position_coordinate_manager_bench

bind position_coordinate_manager pcm_checker chk_u (.*);
